// ### hw/bbd_defs.svh
// Constants for the bit and branch decoder: opcodes, address layout and reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef BBD_DEFS_SVH
`define BBD_DEFS_SVH
`define OP_NO_OPERATION    8'h00
`define OP_LONG_JUMP       8'h02
`define OP_BR_AND_CLEAR    8'h10
`define OP_LONG_CALL       8'h12
`define OP_BR_BIT_SET      8'h20
`define OP_SUB_EXIT        8'h22
`define OP_BR_BIT_CLEAR    8'h30
`define OP_INT_EXIT        8'h32
`define OP_BR_CARRY_SET    8'h40
`define OP_BR_CARRY_CLEAR  8'h50
`define OP_BR_ACC_ZERO     8'h60
`define OP_BR_ACC_NONZERO  8'h70
`define OP_OR_BIT          8'h72
`define OP_IND_JUMP        8'h73
`define OP_REL_JUMP        8'h80
`define OP_AND_BIT         8'h82
`define OP_STORE_CARRY     8'h92
`define OP_OR_NOT_BIT      8'hA0
`define OP_LOAD_CARRY      8'hA2
`define OP_AND_NOT_BIT     8'hB0
`define OP_FLIP_BIT        8'hB2
`define OP_FLIP_CARRY      8'hB3
`define OP_CMP_IMM         8'hB4
`define OP_CMP_DIR         8'hB5
`define OP_CLEAR_BIT       8'hC2
`define OP_CLEAR_CARRY     8'hC3
`define OP_SET_BIT         8'hD2
`define OP_SET_CARRY       8'hD3
`define OP_DEC_DIR         8'hD5
`define PAGE_CALL_LOW      5'h11
`define PAGE_JUMP_LOW      5'h01
`define HI_CMP_REG         4'hB
`define HI_DEC_REG         4'hD
`define CMP_IND_HI         7'h5B
`define BIT_RAM_HI         4'h2
`define RESET_PC           16'h0000
`define RESET_SP           8'h07
`define MC_CLOCKS          12
`define MIN_MC_CLOCKS      8
`define MAX_MC_CLOCKS      31
`define CNT_W              6
`endif

// ### hw/bbd_pkg.sv
// Types shared by the bit and branch decoder files.
// Assumes nothing of its surroundings.
package bbd_pkg;
  typedef enum logic [5:0] {
    i_no_operation, i_clear_carry, i_set_carry, i_complement_carry,
    i_clear_bit, i_set_bit, i_complement_bit, i_and_bit, i_and_not_bit,
    i_or_bit, i_or_not_bit, i_load_carry, i_store_carry, i_short_call,
    i_short_jump, i_long_call, i_long_jump, i_subroutine_exit,
    i_interrupt_exit, i_relative_jump, i_indirect_jump, i_acc_zero,
    i_acc_nonzero, i_carry_set, i_carry_clear, i_bit_set, i_bit_clear,
    i_bit_set_clear, i_cmp_dir, i_cmp_imm, i_cmp_reg, i_cmp_ind,
    i_dec_reg, i_dec_dir, i_bad
  } insn_t;
  typedef enum logic [3:0] {
    s_fetch, s_opcode, s_byte2, s_byte3, s_address, s_register,
    s_operand, s_execute, s_push_high, s_pop_high, s_pop_low, s_wait
  } state_t;
endpackage

// ### hw/bit_and_branch_decoder.sv
// Sequencer that decodes and executes the Boolean and program control groups.
// Assumes program and data memories answer within the clock cycle of each read strobe.
`timescale 1ns/100ps
`include "bbd_defs.svh"
module bit_and_branch_decoder #(
  parameter int MC_CLOCKS = `MC_CLOCKS
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  output logic      [15:0] code_addr,
  output logic             code_rd,
  input  wire logic [7:0]  code_rdata,
  output logic      [7:0]  data_addr,
  output logic             data_special,
  output logic             data_rd,
  output logic             data_wr,
  output logic      [7:0]  data_wdata,
  input  wire logic [7:0]  data_rdata,
  input  wire logic [7:0]  acc,
  input  wire logic [15:0] data_pointer,
  input  wire logic [1:0]  bank,
  output logic             carry,
  output logic      [15:0] pc,
  output logic      [7:0]  sp,
  output logic             insn_done,
  output logic             int_return,
  output logic             bad_opcode
);
  initial begin
    if (MC_CLOCKS < `MIN_MC_CLOCKS || MC_CLOCKS > `MAX_MC_CLOCKS) begin
      $error("MC_CLOCKS out of the range the sequencer can serve");
    end
  end

  bbd_pkg::state_t  state;
  bbd_pkg::insn_t   insn;
  bbd_pkg::insn_t   next_insn;
  logic [7:0]       opcode;
  logic [7:0]       byte2;
  logic [7:0]       byte3;
  logic [7:0]       operand;
  logic [7:0]       op_addr;
  logic             op_special;
  logic [15:0]      target;
  logic [`CNT_W-1:0] cnt;
  logic [7:0]       reg_addr;
  logic [7:0]       bit_byte;
  logic [2:0]       bit_index;
  logic             bit_special;
  logic [1:0]       length;
  logic             two_cycles;
  logic             bit_value;
  logic [7:0]       rel;
  logic [15:0]      rel_target;
  logic [7:0]       cmp_a;
  logic [7:0]       cmp_b;
  logic [7:0]       decremented;
  logic [7:0]       bit_mask;
  logic [`CNT_W-1:0] last_clock;

  operand_address u_operand_address (
    .opcode    (opcode),
    .byte2     (byte2),
    .bank      (bank),
    .reg_addr  (reg_addr),
    .bit_byte  (bit_byte),
    .bit_index (bit_index),
    .bit_special (bit_special)
  );

  function automatic bbd_pkg::insn_t classify(input logic [7:0] op);
    if (op[4:0] == `PAGE_CALL_LOW) return bbd_pkg::i_short_call;
    if (op[4:0] == `PAGE_JUMP_LOW) return bbd_pkg::i_short_jump;
    if (op[7:4] == `HI_CMP_REG && op[3]) return bbd_pkg::i_cmp_reg;
    if (op[7:4] == `HI_DEC_REG && op[3]) return bbd_pkg::i_dec_reg;
    if (op[7:1] == `CMP_IND_HI) return bbd_pkg::i_cmp_ind;
    case (op)
      `OP_NO_OPERATION:   return bbd_pkg::i_no_operation;
      `OP_CLEAR_CARRY:    return bbd_pkg::i_clear_carry;
      `OP_SET_CARRY:      return bbd_pkg::i_set_carry;
      `OP_FLIP_CARRY:     return bbd_pkg::i_complement_carry;
      `OP_CLEAR_BIT:      return bbd_pkg::i_clear_bit;
      `OP_SET_BIT:        return bbd_pkg::i_set_bit;
      `OP_FLIP_BIT:       return bbd_pkg::i_complement_bit;
      `OP_AND_BIT:        return bbd_pkg::i_and_bit;
      `OP_AND_NOT_BIT:    return bbd_pkg::i_and_not_bit;
      `OP_OR_BIT:         return bbd_pkg::i_or_bit;
      `OP_OR_NOT_BIT:     return bbd_pkg::i_or_not_bit;
      `OP_LOAD_CARRY:     return bbd_pkg::i_load_carry;
      `OP_STORE_CARRY:    return bbd_pkg::i_store_carry;
      `OP_LONG_CALL:      return bbd_pkg::i_long_call;
      `OP_LONG_JUMP:      return bbd_pkg::i_long_jump;
      `OP_SUB_EXIT:       return bbd_pkg::i_subroutine_exit;
      `OP_INT_EXIT:       return bbd_pkg::i_interrupt_exit;
      `OP_REL_JUMP:       return bbd_pkg::i_relative_jump;
      `OP_IND_JUMP:       return bbd_pkg::i_indirect_jump;
      `OP_BR_ACC_ZERO:    return bbd_pkg::i_acc_zero;
      `OP_BR_ACC_NONZERO: return bbd_pkg::i_acc_nonzero;
      `OP_BR_CARRY_SET:   return bbd_pkg::i_carry_set;
      `OP_BR_CARRY_CLEAR: return bbd_pkg::i_carry_clear;
      `OP_BR_BIT_SET:     return bbd_pkg::i_bit_set;
      `OP_BR_BIT_CLEAR:   return bbd_pkg::i_bit_clear;
      `OP_BR_AND_CLEAR:   return bbd_pkg::i_bit_set_clear;
      `OP_CMP_DIR:        return bbd_pkg::i_cmp_dir;
      `OP_CMP_IMM:        return bbd_pkg::i_cmp_imm;
      `OP_DEC_DIR:        return bbd_pkg::i_dec_dir;
      default:            return bbd_pkg::i_bad;
    endcase
  endfunction

  function automatic logic [1:0] insn_length(input bbd_pkg::insn_t i);
    unique case (i)
      bbd_pkg::i_no_operation, bbd_pkg::i_clear_carry, bbd_pkg::i_set_carry,
      bbd_pkg::i_complement_carry, bbd_pkg::i_subroutine_exit,
      bbd_pkg::i_interrupt_exit, bbd_pkg::i_indirect_jump, bbd_pkg::i_bad:
        return 2'd1;
      bbd_pkg::i_long_call, bbd_pkg::i_long_jump, bbd_pkg::i_bit_set,
      bbd_pkg::i_bit_clear, bbd_pkg::i_bit_set_clear, bbd_pkg::i_cmp_dir,
      bbd_pkg::i_cmp_imm, bbd_pkg::i_cmp_reg, bbd_pkg::i_cmp_ind,
      bbd_pkg::i_dec_dir:
        return 2'd3;
      default:
        return 2'd2;
    endcase
  endfunction

  // Unknown opcodes are timed as one-cycle no-ops so the core never hangs.
  function automatic logic insn_two_cycles(input bbd_pkg::insn_t i);
    unique case (i)
      bbd_pkg::i_no_operation, bbd_pkg::i_clear_carry, bbd_pkg::i_set_carry,
      bbd_pkg::i_complement_carry, bbd_pkg::i_clear_bit, bbd_pkg::i_set_bit,
      bbd_pkg::i_complement_bit, bbd_pkg::i_load_carry, bbd_pkg::i_bad:
        return 1'b0;
      default:
        return 1'b1;
    endcase
  endfunction

  always_comb begin
    next_insn   = classify(code_rdata);
    length      = insn_length(insn);
    two_cycles  = insn_two_cycles(insn);
    bit_value   = operand[bit_index];
    bit_mask    = 8'h01 << bit_index;
    rel         = (length == 2'd3) ? byte3 : byte2;
    rel_target  = pc + {{8{rel[7]}}, rel};
    decremented = operand - 8'h01;
    cmp_a       = operand;
    cmp_b       = byte2;
    if (insn == bbd_pkg::i_cmp_dir) begin
      cmp_a = acc;
      cmp_b = operand;
    end else if (insn == bbd_pkg::i_cmp_imm) begin
      cmp_a = acc;
    end
    last_clock = two_cycles ? `CNT_W'(2 * MC_CLOCKS - 1) : `CNT_W'(MC_CLOCKS - 1);
  end

  // The instruction clock count runs from the opcode fetch and paces completion.
  always_ff @(posedge mclk) begin
    if (rst || state == bbd_pkg::s_fetch) begin
      cnt <= `CNT_W'(1);
    end else begin
      cnt <= cnt + `CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    code_rd    <= 1'b0;
    data_rd    <= 1'b0;
    data_wr    <= 1'b0;
    insn_done  <= 1'b0;
    int_return <= 1'b0;
    if (rst) begin
      state      <= bbd_pkg::s_fetch;
      insn       <= bbd_pkg::i_no_operation;
      pc         <= `RESET_PC;
      sp         <= `RESET_SP;
      carry      <= 1'b0;
      code_addr  <= `RESET_PC;
      data_addr  <= 8'h00;
      data_special <= 1'b0;
      data_wdata <= 8'h00;
      opcode     <= 8'h00;
      byte2      <= 8'h00;
      byte3      <= 8'h00;
      operand    <= 8'h00;
      op_addr    <= 8'h00;
      op_special <= 1'b0;
      target     <= 16'h0000;
      bad_opcode <= 1'b0;
    end else begin
      unique case (state)
        bbd_pkg::s_fetch: begin
          code_addr <= pc;
          code_rd   <= 1'b1;
          pc        <= pc + 16'h0001;
          state     <= bbd_pkg::s_opcode;
        end
        bbd_pkg::s_opcode: begin
          opcode     <= code_rdata;
          insn       <= next_insn;
          bad_opcode <= (next_insn == bbd_pkg::i_bad);
          if (insn_length(next_insn) != 2'd1) begin
            code_addr <= pc;
            code_rd   <= 1'b1;
            pc        <= pc + 16'h0001;
            state     <= bbd_pkg::s_byte2;
          end else begin
            state <= bbd_pkg::s_address;
          end
        end
        bbd_pkg::s_byte2: begin
          byte2 <= code_rdata;
          if (length == 2'd3) begin
            code_addr <= pc;
            code_rd   <= 1'b1;
            pc        <= pc + 16'h0001;
            state     <= bbd_pkg::s_byte3;
          end else begin
            state <= bbd_pkg::s_address;
          end
        end
        bbd_pkg::s_byte3: begin
          byte3 <= code_rdata;
          state <= bbd_pkg::s_address;
        end
        bbd_pkg::s_address: begin
          state <= bbd_pkg::s_execute;
          unique case (insn)
            bbd_pkg::i_cmp_reg, bbd_pkg::i_dec_reg, bbd_pkg::i_cmp_ind: begin
              data_addr <= reg_addr;
              data_special <= 1'b0;
              data_rd   <= 1'b1;
              op_addr   <= reg_addr;
              op_special <= 1'b0;
              state     <= bbd_pkg::s_register;
            end
            bbd_pkg::i_cmp_dir, bbd_pkg::i_dec_dir: begin
              data_addr <= byte2;
              data_special <= byte2[7];
              data_rd   <= 1'b1;
              op_addr   <= byte2;
              op_special <= byte2[7];
              state     <= bbd_pkg::s_operand;
            end
            bbd_pkg::i_clear_bit, bbd_pkg::i_set_bit, bbd_pkg::i_complement_bit,
            bbd_pkg::i_and_bit, bbd_pkg::i_and_not_bit, bbd_pkg::i_or_bit,
            bbd_pkg::i_or_not_bit, bbd_pkg::i_load_carry, bbd_pkg::i_store_carry,
            bbd_pkg::i_bit_set, bbd_pkg::i_bit_clear, bbd_pkg::i_bit_set_clear: begin
              data_addr <= bit_byte;
              data_special <= bit_special;
              data_rd   <= 1'b1;
              op_addr   <= bit_byte;
              op_special <= bit_special;
              state     <= bbd_pkg::s_operand;
            end
            bbd_pkg::i_subroutine_exit, bbd_pkg::i_interrupt_exit: begin
              data_addr <= sp;
              data_special <= 1'b0;
              data_rd   <= 1'b1;
              state     <= bbd_pkg::s_pop_high;
            end
            default: begin
            end
          endcase
        end
        bbd_pkg::s_register: begin
          operand <= data_rdata;
          if (insn == bbd_pkg::i_cmp_ind) begin
            // Indirect reads never reach the special register space, even above 7F.
            data_addr <= data_rdata;
            data_rd   <= 1'b1;
            state     <= bbd_pkg::s_operand;
          end else begin
            state <= bbd_pkg::s_execute;
          end
        end
        bbd_pkg::s_operand: begin
          operand <= data_rdata;
          state   <= bbd_pkg::s_execute;
        end
        bbd_pkg::s_execute: begin
          state      <= bbd_pkg::s_wait;
          data_addr  <= op_addr;
          data_special <= op_special;
          data_wdata <= operand;
          unique case (insn)
            bbd_pkg::i_clear_carry:      carry <= 1'b0;
            bbd_pkg::i_set_carry:        carry <= 1'b1;
            bbd_pkg::i_complement_carry: carry <= ~carry;
            bbd_pkg::i_clear_bit: begin
              data_wdata <= operand & ~bit_mask;
              data_wr    <= 1'b1;
            end
            bbd_pkg::i_set_bit: begin
              data_wdata <= operand | bit_mask;
              data_wr    <= 1'b1;
            end
            bbd_pkg::i_complement_bit: begin
              data_wdata <= operand ^ bit_mask;
              data_wr    <= 1'b1;
            end
            bbd_pkg::i_and_bit:     carry <= carry & bit_value;
            bbd_pkg::i_and_not_bit: carry <= carry & ~bit_value;
            bbd_pkg::i_or_bit:      carry <= carry | bit_value;
            bbd_pkg::i_or_not_bit:  carry <= carry | ~bit_value;
            bbd_pkg::i_load_carry:  carry <= bit_value;
            bbd_pkg::i_store_carry: begin
              data_wdata <= carry ? (operand | bit_mask) : (operand & ~bit_mask);
              data_wr    <= 1'b1;
            end
            bbd_pkg::i_short_jump: pc <= {pc[15:11], opcode[7:5], byte2};
            bbd_pkg::i_long_jump:  pc <= {byte2, byte3};
            bbd_pkg::i_short_call, bbd_pkg::i_long_call: begin
              // The return address low byte goes first, the high byte next clock.
              if (insn == bbd_pkg::i_short_call) begin
                target <= {pc[15:11], opcode[7:5], byte2};
              end else begin
                target <= {byte2, byte3};
              end
              data_addr  <= sp + 8'h01;
              data_special <= 1'b0;
              data_wdata <= pc[7:0];
              data_wr    <= 1'b1;
              state      <= bbd_pkg::s_push_high;
            end
            bbd_pkg::i_relative_jump: pc <= rel_target;
            bbd_pkg::i_indirect_jump: pc <= data_pointer + {8'h00, acc};
            bbd_pkg::i_acc_zero:      if (acc == 8'h00) pc <= rel_target;
            bbd_pkg::i_acc_nonzero:   if (acc != 8'h00) pc <= rel_target;
            bbd_pkg::i_carry_set:     if (carry) pc <= rel_target;
            bbd_pkg::i_carry_clear:   if (!carry) pc <= rel_target;
            bbd_pkg::i_bit_set:       if (bit_value) pc <= rel_target;
            bbd_pkg::i_bit_clear:     if (!bit_value) pc <= rel_target;
            bbd_pkg::i_bit_set_clear: begin
              if (bit_value) begin
                pc         <= rel_target;
                data_wdata <= operand & ~bit_mask;
                data_wr    <= 1'b1;
              end
            end
            bbd_pkg::i_cmp_dir, bbd_pkg::i_cmp_imm, bbd_pkg::i_cmp_reg,
            bbd_pkg::i_cmp_ind: begin
              // Carry reports an unsigned first-below-second result.
              carry <= (cmp_a < cmp_b);
              if (cmp_a != cmp_b) pc <= rel_target;
            end
            bbd_pkg::i_dec_reg, bbd_pkg::i_dec_dir: begin
              data_wdata <= decremented;
              data_wr    <= 1'b1;
              if (decremented != 8'h00) pc <= rel_target;
            end
            default: begin
            end
          endcase
        end
        bbd_pkg::s_push_high: begin
          data_addr  <= sp + 8'h02;
          data_wdata <= pc[15:8];
          data_wr    <= 1'b1;
          sp         <= sp + 8'h02;
          pc         <= target;
          state      <= bbd_pkg::s_wait;
        end
        bbd_pkg::s_pop_high: begin
          target[15:8] <= data_rdata;
          data_addr    <= sp - 8'h01;
          data_rd      <= 1'b1;
          state        <= bbd_pkg::s_pop_low;
        end
        bbd_pkg::s_pop_low: begin
          pc         <= {target[15:8], data_rdata};
          sp         <= sp - 8'h02;
          int_return <= (insn == bbd_pkg::i_interrupt_exit);
          state      <= bbd_pkg::s_wait;
        end
        bbd_pkg::s_wait: begin
          // Completion is held back so every instruction spans whole machine cycles.
          if (cnt == last_clock) begin
            insn_done <= 1'b1;
            state     <= bbd_pkg::s_fetch;
          end
        end
      endcase
    end
  end
endmodule

// ### hw/operand_address.sv
// Operand address resolver: working register, direct bit byte and bit index.
// Assumes a stable opcode, second byte and bank select from the sequencer.
`timescale 1ns/100ps
`include "bbd_defs.svh"
module operand_address (
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] byte2,
  input  wire logic [1:0] bank,
  output logic      [7:0] reg_addr,
  output logic      [7:0] bit_byte,
  output logic      [2:0] bit_index,
  output logic            bit_special
);
  always_comb begin
    // Indirect forms use opcode bit 0 to pick R0 or R1 of the current bank.
    if (opcode[7:1] == `CMP_IND_HI) begin
      reg_addr = {3'h0, bank, 2'h0, opcode[0]};
    end else begin
      reg_addr = {3'h0, bank, opcode[2:0]};
    end
    // Bits below the boundary live in a 16-byte RAM window; above it in special register bytes.
    if (byte2[7]) begin
      bit_byte = {byte2[7:3], 3'h0};
    end else begin
      bit_byte = {`BIT_RAM_HI, byte2[6:3]};
    end
    bit_index = byte2[2:0];
    bit_special = byte2[7];
  end
endmodule

// ### tb/bbd_assertions.sv
// Checker for the bit and branch decoder: instruction length, carry, stack and the indirect jump target.
// Assumes binding to the decoder top while acc and the data pointer are held steady.
`timescale 1ns/100ps
module bbd_assertions #(
  parameter int MC_CLOCKS = 12
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [15:0] code_addr,
  input wire logic        code_rd,
  input wire logic [7:0]  code_rdata,
  input wire logic [7:0]  acc,
  input wire logic [15:0] data_pointer,
  input wire logic        carry,
  input wire logic [7:0]  sp,
  input wire logic        insn_done
);
  // The opcode is rebuilt from the fetch order, since the decoder does not export it.
  logic [5:0] cnt;
  logic [7:0] op;
  logic [7:0] sp0;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Reset is seen one edge before the first fetch, so the count starts one below zero.
  always_ff @(posedge mclk) begin
    cnt <= rst ? 6'h3F : (insn_done ? 6'h00 : cnt + 6'h01);
    if (cnt == 6'h00) begin
      op  <= code_rdata;
      sp0 <= sp;
    end
  end
  property p_len; insn_done |-> cnt == MC_CLOCKS - 1 || cnt == 2 * MC_CLOCKS - 1; endproperty
  a_len: assert property (p_len) else $error("bad instruction length");
  property p_fetch; insn_done |=> code_rd; endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch after done");
  property p_idle; insn_done && op == 8'h00 |-> cnt == MC_CLOCKS - 1; endproperty
  a_idle: assert property (p_idle) else $error("idle opcode length");
  property p_set; insn_done && op == 8'hD3 |=> carry; endproperty
  a_set: assert property (p_set) else $error("carry not set");
  property p_clear; insn_done && op == 8'hC3 |=> !carry; endproperty
  a_clear: assert property (p_clear) else $error("carry not cleared");
  property p_ind;
    insn_done && op == 8'h73 |=> code_addr == data_pointer + {8'h00, acc};
  endproperty
  a_ind: assert property (p_ind) else $error("indirect target wrong");
  property p_pop; insn_done && op == 8'h22 |=> sp == sp0 - 8'h02; endproperty
  a_pop: assert property (p_pop) else $error("stack after return");
  property p_call; insn_done && op == 8'h12 |=> sp == sp0 + 8'h02; endproperty
  a_call: assert property (p_call) else $error("stack after call");
  property p_one; insn_done && op == 8'hA2 |-> cnt == MC_CLOCKS - 1; endproperty
  a_one: assert property (p_one) else $error("bit load length");
  property p_two; insn_done && op == 8'h92 |-> cnt == 2 * MC_CLOCKS - 1; endproperty
  a_two: assert property (p_two) else $error("bit store length");
endmodule

// ### tb/mem_model.sv
// Program and internal data memory answering within the cycle of each read strobe.
// Assumes the bench loads program bytes through the rom array just before it pulses the core reset.
`timescale 1ns/100ps
module mem_model (
  input  wire logic        mclk,
  input  wire logic [15:0] code_addr,
  input  wire logic        code_rd,
  output logic      [7:0]  code_rdata,
  input  wire logic [7:0]  data_addr,
  input  wire logic        data_special,
  input  wire logic        data_rd,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wdata,
  output logic      [7:0]  data_rdata
);
  logic [7:0] rom [0:65535];
  logic [7:0] ram [0:255];
  logic [7:0] special_ram [0:255];
  logic [7:0] code_last = 8'h00;
  logic [7:0] data_last = 8'h00;
  initial begin
    for (int i = 0; i < 65536; i++) rom[i] = 8'h00;
    for (int i = 0; i < 256; i++) ram[i] = 8'h00;
    for (int i = 0; i < 256; i++) special_ram[i] = 8'h00;
  end
  // The core takes read data at the edge that closes its strobe cycle, so reads answer at once.
  // Between reads the buses show the inverse of their last value, so stale data never passes.
  assign code_rdata = code_rd ? rom[code_addr] : ~code_last;
  assign data_rdata = data_rd ? (data_special ? special_ram[data_addr] : ram[data_addr])
                              : ~data_last;
  always @(posedge mclk) begin
    code_last <= code_rdata;
    data_last <= data_rdata;
    if (data_wr && data_special) special_ram[data_addr] <= data_wdata;
    if (data_wr && !data_special) ram[data_addr] <= data_wdata;
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the bit and branch decoder with a memory model.
// Assumes acc, data pointer and bank stay fixed; programs load just before each reset pulse.
`timescale 1ns/100ps
module testbench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  acc = 8'h10;
  logic [15:0] data_pointer = 16'h2000;
  logic [1:0]  bank = 2'h1;
  logic [15:0] code_addr, pc;
  logic [7:0]  code_rdata, data_addr, data_wdata, data_rdata, sp;
  logic        code_rd, data_special, data_rd, data_wr, carry, insn_done, int_return;
  logic        saw_ir, bad_opcode;
  int          fail_count = 0;
  int          cmp_count = 0;
  always #50 mclk = ~mclk;
  bit_and_branch_decoder #(.MC_CLOCKS(8)) dut (.mclk(mclk), .rst(rst),
    .code_addr(code_addr), .code_rd(code_rd), .code_rdata(code_rdata),
    .data_addr(data_addr), .data_special(data_special), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rdata(data_rdata), .acc(acc), .data_pointer(data_pointer),
    .bank(bank), .carry(carry), .pc(pc), .sp(sp), .insn_done(insn_done),
    .int_return(int_return), .bad_opcode(bad_opcode));
  mem_model mem (.mclk(mclk), .code_addr(code_addr), .code_rd(code_rd),
    .code_rdata(code_rdata), .data_addr(data_addr), .data_special(data_special),
    .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [23:0] b, input int n);
    for (int i = 0; i < n; i++) mem.rom[a + 16'(i)] = b[23 - 8 * i -: 8];
  endtask
  task automatic boot;
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
  endtask
  // Returns inside the done pulse, before the next fetch moves pc on; a hang counts as a mismatch.
  task automatic step;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      if (int_return === 1'b1) saw_ir = 1'b1;
    end while (insn_done !== 1'b1 && n < 200);
    if (insn_done !== 1'b1) fail_count++;
  endtask
  task automatic t_carry;
    logic [4:0] e;
    e = 5'b10100;
    put(16'h0000, 24'hD3B3B3, 3);
    put(16'h0003, 24'hC3A500, 2);
    boot;
    for (int i = 0; i < 5; i++) begin
      step;
      cmp(16'(carry), 16'(e[4 - i]));
    end
    cmp(16'(bad_opcode), 16'h0001);
  endtask
  task automatic t_bits;
    logic [159:0] p;
    logic [9:0]   e;
    p = 160'hD205A205B0057205920BA0058206C205B205D288;
    e = 10'b0101110000;
    for (int i = 0; i < 20; i++) mem.rom[i] = p[159 - 8 * i -: 8];
    boot;
    for (int i = 0; i < 10; i++) begin
      step;
      cmp(16'(carry), 16'(e[9 - i]));
    end
    cmp(16'(mem.ram[8'h20]), 16'h0020);
    cmp(16'(mem.ram[8'h21]), 16'h0008);
    cmp(16'(mem.special_ram[8'h88]), 16'h0001);
  endtask
  task automatic t_flow;
    logic [15:0] ep [19] = '{16'h1234, 16'h1056, 16'h1236, 16'h2010, 16'h2012, 16'h2004,
      16'h2006, 16'h1F88, 16'h1F88, 16'h1F8A, 16'h1F8D, 16'h1FC0, 16'h1FC3, 16'h1FC5,
      16'h1FCD, 16'h3000, 16'h1FD0, 16'h1FD4, 16'h1FD4};
    put(16'h0000, 24'h021234, 3);
    put(16'h1234, 24'h115600, 2);
    put(16'h1056, 24'h320000, 1);
    put(16'h1236, 24'h730000, 1);
    put(16'h2010, 24'h600500, 2);
    put(16'h2012, 24'h70F000, 2);
    put(16'h2004, 24'h400200, 2);
    put(16'h2006, 24'h508000, 2);
    put(16'h1F88, 24'hDAFE00, 2);
    put(16'h1F8A, 24'hB41003, 3);
    put(16'h1F8D, 24'hBA0530, 3);
    put(16'h1FC0, 24'h200B10, 3);
    put(16'h1FC3, 24'hD20D00, 2);
    put(16'h1FC5, 24'h100D05, 3);
    put(16'h1FCD, 24'h123000, 3);
    put(16'h3000, 24'h220000, 1);
    put(16'h1FD0, 24'h800200, 2);
    put(16'h1FD4, 24'h80FE00, 2);
    mem.ram[8'h21] = 8'h00;
    mem.ram[8'h0A] = 8'h02;
    saw_ir = 1'b0;
    boot;
    for (int i = 0; i < 19; i++) begin
      step;
      cmp(pc, ep[i]);
    end
    cmp(16'(saw_ir), 16'h0001);
    cmp({mem.ram[8'h09], mem.ram[8'h08]}, 16'h1FD0);
    cmp(16'(mem.ram[8'h21]), 16'h0000);
    cmp(16'(mem.ram[8'h0A]), 16'h0000);
    cmp(16'(carry), 16'h0001);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #500000;
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_carry;
    t_bits;
    t_flow;
    stop_test;
  end
endmodule
bind bit_and_branch_decoder bbd_assertions #(.MC_CLOCKS(MC_CLOCKS)) chk (.mclk(mclk),
  .rst(rst), .code_addr(code_addr), .code_rd(code_rd), .code_rdata(code_rdata),
  .acc(acc), .data_pointer(data_pointer), .carry(carry), .sp(sp), .insn_done(insn_done));
